// >>> dtp_ddr3_timing.sv
// PHY command timing checker and its AXI4-Lite timing register file
`timescale 1ns/100ps
`include "dtp_params.svh"
module dtp_ddr3_timing
#(
  parameter int BANKS = `DTP_BANKS
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire dtp_pkg::dtp_req_t cmdReq,
  input wire logic ckeLow,
  input wire logic levelDqsRise,
  input wire logic levelEntry,
  input wire logic dllRelock,
  output dtp_pkg::dtp_req_t cmdIssue,
  output logic cmdReady,
  output logic ckeOut,
  output logic levelSample,
  output logic levelStrobeOk,
  output logic dllLocked
);
  import dtp_pkg::*;

  // ==========================================================
  // Register file
  logic [31:0] sysCfg_q, tpA_q, tpB_q, tpC_q;
  logic [3:0] awAddr_q;
  logic awHave_q, wHave_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  wire doWrite = awHave_q && wHave_q && !s_axi_bvalid;
  wire wrMapped = (awAddr_q[1:0] == 2'h0);

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= 4'h0;
      wData_q <= 32'h0;
      wStrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DTP_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !awHave_q && !s_axi_awready;
      s_axi_wready <= !wHave_q && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHave_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? `DTP_RESP_OKAY : `DTP_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
      end
    end
  end

  // Default values are the fastest speed grade
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sysCfg_q <= `DTP_RST_SYSCFG;
      tpA_q <= `DTP_RST_TPA;
      tpB_q <= `DTP_RST_TPB;
      tpC_q <= `DTP_RST_TPC;
    end
    else if (doWrite && wrMapped)
    begin
      case (awAddr_q)
        `DTP_OFF_SYSCFG: sysCfg_q <= mergeBytes(sysCfg_q, wData_q, wStrb_q);
        `DTP_OFF_TPA: tpA_q <= mergeBytes(tpA_q, wData_q, wStrb_q);
        `DTP_OFF_TPB: tpB_q <= mergeBytes(tpB_q, wData_q, wStrb_q) & 32'h3FFFFFFF;
        `DTP_OFF_TPC: tpC_q <= mergeBytes(tpC_q, wData_q, wStrb_q);
        default: sysCfg_q <= sysCfg_q;
      endcase
    end
  end

  // Read: address on the request, data one cycle later
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `DTP_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `DTP_RESP_OKAY;
        case (s_axi_araddr)
          `DTP_OFF_SYSCFG: s_axi_rdata <= sysCfg_q;
          `DTP_OFF_TPA: s_axi_rdata <= tpA_q;
          `DTP_OFF_TPB: s_axi_rdata <= tpB_q;
          `DTP_OFF_TPC: s_axi_rdata <= tpC_q;
          default:
          begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `DTP_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Field decode
  wire [5:0] fRc = tpA_q[31:26];
  wire [3:0] fRrd = tpA_q[25:22];
  wire [5:0] fRas = tpA_q[21:16];
  wire [3:0] fRcd = tpA_q[15:12];
  wire [3:0] fRp = tpA_q[11:8];
  wire [3:0] fWtr = tpA_q[7:4];
  wire [3:0] fRtp = tpA_q[3:0];
  wire [3:0] fWlo = tpB_q[29:26];
  wire [5:0] fWlmrd = tpB_q[25:20];
  wire [8:0] fRfc = tpB_q[19:11];
  wire [5:0] fFaw = tpB_q[10:5];
  wire [2:0] fMod = tpB_q[4:2];
  wire [1:0] fMrd = tpB_q[1:0];
  wire [9:0] fDllk = tpC_q[28:19];
  wire [3:0] fCke = tpC_q[18:15];
  wire [4:0] fXp = tpC_q[14:10];
  wire [9:0] fXs = tpC_q[9:0];
  // Normal traffic uses controller timing; these only shape PHY commands
  wire [5:0] ccdCyc = `DTP_CCD_BASE + {5'h0, tpC_q[31]};
  wire [5:0] rtwCyc = `DTP_RTW_BASE + {5'h0, tpC_q[30]};
  wire [5:0] rtodtCyc = `DTP_RTODT_BASE + {5'h0, tpC_q[29]};
  wire [5:0] modCyc = `DTP_MOD_BASE + {3'h0, fMod};
  wire [5:0] mrdCyc = `DTP_MRD_BASE + {4'h0, fMrd};

  // Load a count so that the next command waits cnt cycles after this one
  function automatic logic [9:0] loadGap(input logic [9:0] cnt);
    return (cnt > 10'h1) ? cnt - 10'h1 : 10'h0;
  endfunction
  function automatic logic [9:0] tick(input logic [9:0] c);
    return (c != 10'h0) ? c - 10'h1 : 10'h0;
  endfunction

  // ==========================================================
  // Gap counters
  // Same-direction column gaps kept apart so read-to-write follows its own count
  typedef enum logic [3:0] {
    G_RRD, G_PRE, G_WTR, G_RW, G_RFC, G_MOD, G_MRD, G_XP, G_RTW, G_WW
  } dtp_gap_t;
  logic [9:0] gap_q [10];
  logic [9:0] bankRc_q [BANKS];
  logic [9:0] bankRas_q [BANKS];
  logic [9:0] bankRcd_q [BANKS];
  logic [9:0] bankRtp_q [BANKS];
  logic [5:0] fawAge_q [4];

  dtp_req_t r;
  assign r = cmdReq;
  wire [2:0] b = r.bank;
  logic allowed;
  logic [2:0] fawBusy;

  always_comb
  begin
    fawBusy = 3'h0;
    for (int i = 0; i < 4; i++)
      fawBusy = fawBusy + {2'h0, (fawAge_q[i] != 6'h0)};
    allowed = (gap_q[G_PRE] == 10'h0) && (gap_q[G_XP] == 10'h0);
    case (r.cmd)
      CMD_ACT: allowed = allowed && bankRc_q[b] == 10'h0
        && gap_q[G_RRD] == 10'h0
        && gap_q[G_RFC] == 10'h0
        && fawBusy < `DTP_FAW_ACTS
        && gap_q[G_MOD] == 10'h0;
      CMD_PRE: allowed = allowed && bankRas_q[b] == 10'h0
        && bankRtp_q[b] == 10'h0 && gap_q[G_MOD] == 10'h0;
      CMD_RD: allowed = allowed && bankRcd_q[b] == 10'h0
        && gap_q[G_WTR] == 10'h0 && gap_q[G_RW] == 10'h0
        && gap_q[G_MOD] == 10'h0;
      CMD_WR: allowed = allowed && bankRcd_q[b] == 10'h0
        && gap_q[G_WW] == 10'h0 && gap_q[G_RTW] == 10'h0
        && gap_q[G_MOD] == 10'h0;
      CMD_REF: allowed = allowed && gap_q[G_RFC] == 10'h0 && gap_q[G_MOD] == 10'h0;
      CMD_MRS: allowed = allowed && gap_q[G_MRD] == 10'h0;
      CMD_PDX: allowed = allowed && gap_q[G_MOD] == 10'h0;
      default: allowed = 1'b0;
    endcase
  end

  logic [9:0] ckeCnt_q;
  logic ckeHold;
  assign ckeHold = (ckeCnt_q != 10'h0) && !ckeOut;
  wire fire = r.valid && allowed && !ckeHold && dllLocked;

  // counters load on the issuing command and count down to zero
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < 10; i++)
        gap_q[i] <= 10'h0;
      for (int k = 0; k < BANKS; k++)
      begin
        bankRc_q[k] <= 10'h0;
        bankRas_q[k] <= 10'h0;
        bankRcd_q[k] <= 10'h0;
        bankRtp_q[k] <= 10'h0;
      end
      for (int j = 0; j < 4; j++)
        fawAge_q[j] <= 6'h0;
    end
    else
    begin
      for (int i = 0; i < 10; i++)
        gap_q[i] <= tick(gap_q[i]);
      for (int k = 0; k < BANKS; k++)
      begin
        bankRc_q[k] <= tick(bankRc_q[k]);
        bankRas_q[k] <= tick(bankRas_q[k]);
        bankRcd_q[k] <= tick(bankRcd_q[k]);
        bankRtp_q[k] <= tick(bankRtp_q[k]);
      end
      for (int j = 0; j < 4; j++)
        fawAge_q[j] <= (fawAge_q[j] != 6'h0) ? fawAge_q[j] - 6'h1 : 6'h0;
      if (fire)
      begin
        case (r.cmd)
          CMD_ACT:
          begin
            bankRc_q[b] <= loadGap({4'h0, fRc});
            bankRas_q[b] <= loadGap({4'h0, fRas});
            bankRcd_q[b] <= loadGap({6'h0, fRcd});
            gap_q[G_RRD] <= loadGap({6'h0, fRrd});
            fawAge_q[0] <= (fFaw > 6'h1) ? fFaw - 6'h1 : 6'h0;
            for (int j = 1; j < 4; j++)
              fawAge_q[j] <= (fawAge_q[j-1] != 6'h0) ? fawAge_q[j-1] - 6'h1 : 6'h0;
          end
          CMD_PRE: gap_q[G_PRE] <= loadGap({6'h0, fRp});
          CMD_RD:
          begin
            bankRtp_q[b] <= loadGap({6'h0, fRtp});
            gap_q[G_RW] <= loadGap({4'h0, ccdCyc});
            gap_q[G_RTW] <= loadGap({4'h0, rtwCyc + rtodtCyc});
          end
          CMD_WR:
          begin
            gap_q[G_WTR] <= loadGap({6'h0, fWtr});
            gap_q[G_WW] <= loadGap({4'h0, ccdCyc});
          end
          CMD_REF: gap_q[G_RFC] <= loadGap({1'h0, fRfc});
          CMD_MRS:
          begin
            gap_q[G_MOD] <= loadGap({4'h0, modCyc});
            gap_q[G_MRD] <= loadGap({4'h0, mrdCyc});
          end
          CMD_PDX: gap_q[G_XP] <= loadGap(r.srefExit ? fXs : {5'h0, fXp});
          default: gap_q[G_RW] <= tick(gap_q[G_RW]);
        endcase
      end
    end
  end

  // ==========================================================
  // Clock enable, leveling, DLL lock
  logic [9:0] wloCnt_q, wlmrdCnt_q, dllCnt_q;
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ckeOut <= 1'b1;
      ckeCnt_q <= 10'h0;
    end
    else if (ckeLow != !ckeOut && ckeCnt_q == 10'h0)
    begin
      ckeOut <= !ckeLow;
      ckeCnt_q <= loadGap({6'h0, fCke});
    end
    else
      ckeCnt_q <= tick(ckeCnt_q);
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wloCnt_q <= 10'h0;
      levelSample <= 1'b0;
      wlmrdCnt_q <= 10'h0;
      levelStrobeOk <= 1'b0;
    end
    else
    begin
      levelSample <= (wloCnt_q == 10'h1);
      if (levelDqsRise)
        wloCnt_q <= {6'h0, fWlo};
      else
        wloCnt_q <= tick(wloCnt_q);
      if (levelEntry)
      begin
        wlmrdCnt_q <= {4'h0, fWlmrd};
        levelStrobeOk <= 1'b0;
      end
      else
      begin
        wlmrdCnt_q <= tick(wlmrdCnt_q);
        levelStrobeOk <= levelStrobeOk || (wlmrdCnt_q <= 10'h1);
      end
    end
  end

  // Lock wait restarts whenever the memory DLL is reset
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dllCnt_q <= 10'h0;
      dllLocked <= 1'b0;
    end
    else if (dllRelock)
    begin
      dllCnt_q <= fDllk;
      dllLocked <= 1'b0;
    end
    else
    begin
      dllCnt_q <= tick(dllCnt_q);
      dllLocked <= (dllCnt_q <= 10'h1);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmdIssue <= '0;
      cmdReady <= 1'b0;
    end
    else
    begin
      cmdIssue <= fire ? r : '0;
      cmdReady <= fire;
    end
  end
endmodule

// >>> dtp_ddr3_timing_asserts.sv
// Port assertions of the DDR3 command timing block
`timescale 1ns/100ps
module dtp_ddr3_timing_asserts
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire dtp_pkg::dtp_req_t cmdReq,
  input wire dtp_pkg::dtp_req_t cmdIssue,
  input wire logic cmdReady,
  input wire logic ckeOut,
  input wire logic dllRelock,
  input wire logic dllLocked,
  input wire logic levelEntry,
  input wire logic levelStrobeOk,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  import dtp_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  // ==========
  // Command path
  chk_issue_match:
    assert property (cmdReady |-> cmdIssue.valid && cmdIssue.cmd == $past(cmdReq.cmd))
    else $error("Issued command differs from request");
  chk_ready_pulse:
    assert property (cmdReady |=> !cmdReady)
    else $error("Command accept longer than one cycle");
  chk_issue_locked:
    assert property (cmdReady |-> $past(dllLocked))
    else $error("Command issued without DLL lock");
  chk_relock_wait:
    assert property (dllRelock |=> !dllLocked [*2])
    else $error("DLL lock reported too soon");
  chk_strobe_hold:
    assert property (levelEntry |=> !levelStrobeOk)
    else $error("Strobe allowed right after leveling entry");
  chk_cke_pulse:
    assert property ($fell(ckeOut) |=> !ckeOut)
    else $error("Clock enable low pulse too short");
  // ==========
  // Register bus
  chk_bad_addr:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0
      |=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("Unaligned read not refused");
  chk_rvalid_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read answer dropped early");
  chk_bvalid_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("Write answer dropped early");
  cover property (cmdReady && cmdIssue.cmd == CMD_ACT);
  cover property ($fell(ckeOut));
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

// >>> dtp_ddr3_timing_tb_top.sv
// Self-checking bench of the DDR3 command timing block
`timescale 1ns/100ps
`include "dtp_params.svh"
module dtp_ddr3_timing_tb_top;
  import dtp_pkg::*;
  localparam logic [31:0] TPA = {6'h28, 4'h5, 6'h09, 4'h6, 4'h7, 4'h8, 4'h3};
  localparam logic [31:0] TPB = {2'h0, 4'hC, 6'h0A, 9'h01E, 6'h28, 3'h5, 2'h3};
  localparam logic [31:0] TPC = {3'h5, 10'h014, 4'h5, 5'h09, 10'h028};
  logic core_clk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic ckeLow, levelDqsRise, levelEntry, dllRelock, cmdReady, ckeOut, levelSample;
  logic levelStrobeOk, dllLocked;
  dtp_req_t cmdReq, cmdIssue;
  logic [7:0] protoErr, issueCnt;
  int fails, checks, n;
  dtp_ddr3_timing DUT (.core_clk(core_clk), .arst_n(arst_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .cmdReq(cmdReq), .ckeLow(ckeLow), .levelDqsRise(levelDqsRise),
    .levelEntry(levelEntry), .dllRelock(dllRelock), .cmdIssue(cmdIssue), .cmdReady(cmdReady),
    .ckeOut(ckeOut), .levelSample(levelSample), .levelStrobeOk(levelStrobeOk),
    .dllLocked(dllLocked));
  dtp_sdram_model u_sdram (.core_clk(core_clk), .arst_n(arst_n), .cmdIssue(cmdIssue),
    .ckeOut(ckeOut), .protoErr(protoErr), .issueCnt(issueCnt));
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // ==========
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (fails == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic bound(input int cnt);
    if (cnt >= 2000)
    begin
      fails++;
      final_report();
    end
  endtask
  task automatic axiWr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] resp);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 2000; n++)
    begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
        break;
    end
    bound(n);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, resp);
    @(posedge core_clk);
  endtask
  task automatic axiRd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] resp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 2000; n++)
    begin
      @(posedge core_clk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
        break;
    end
    bound(n);
    s_axi_rready <= 1'b0;
    check(s_axi_rresp, resp);
    check(s_axi_rdata, exp);
    @(posedge core_clk);
  endtask
  // Counts edges until the selected output reaches its level, then checks the range
  task automatic span(input int sel, input int lo, input int hi);
    for (n = 1; n < 2000; n++)
    begin
      @(posedge core_clk);
      if ((sel == 0 && dllLocked === 1'b1) || (sel == 1 && levelStrobeOk === 1'b1)
        || (sel == 2 && levelSample === 1'b1) || (sel == 3 && ckeOut === 1'b1)
        || (sel == 4 && ckeOut === 1'b0))
        break;
    end
    bound(n);
    check(n >= lo && n <= hi, 32'h1);
  endtask
  // Gap is edges since the previous accept; zero skips the spacing compare
  task automatic step(input dtp_cmd_e_t c, input int b, input int s, input int gap);
    cmdReq <= '{1'b1, c, 3'(b), 1'(s)};
    for (n = 1; n < 2000; n++)
    begin
      @(posedge core_clk);
      if (cmdReady === 1'b1)
        break;
    end
    bound(n);
    check(cmdIssue, {1'b1, c, 3'(b), 1'(s)});
    if (gap > 0)
      check(n, gap);
  endtask
  // ==========
  // Main sequence
  initial
  begin
    arst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = {8'h00, 4'hF, 32'h0};
    {cmdReq, ckeLow, levelDqsRise, levelEntry, dllRelock} = 12'h000;
    fails = 0;
    checks = 0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    axiRd(`DTP_OFF_SYSCFG, 32'h0000040B, `DTP_RESP_OKAY);
    axiRd(`DTP_OFF_TPA, {6'h32, 4'h7, 6'h24, 4'hE, 4'hE, 4'h8, 4'h8}, 2'h0);
    axiRd(`DTP_OFF_TPB, {2'h0, 4'h8, 6'h28, 9'h176, 6'h26, 3'h4, 2'h2}, 2'h0);
    axiRd(`DTP_OFF_TPC, {3'h0, 10'h200, 4'h6, 5'h1A, 10'h200}, 2'h0);
    axiRd(4'h2, 32'h0, `DTP_RESP_SLVERR);
    axiWr(`DTP_OFF_TPA, TPA, `DTP_RESP_OKAY);
    axiWr(`DTP_OFF_TPB, TPB | 32'hC0000000, `DTP_RESP_OKAY);
    axiWr(`DTP_OFF_TPC, TPC, `DTP_RESP_OKAY);
    axiWr(4'h6, 32'hFFFFFFFF, `DTP_RESP_SLVERR);
    axiRd(`DTP_OFF_TPA, TPA, 2'h0);
    axiRd(`DTP_OFF_TPB, TPB, 2'h0);
    axiRd(`DTP_OFF_TPC, TPC, 2'h0);
    dllRelock <= 1'b1;
    @(posedge core_clk);
    dllRelock <= 1'b0;
    span(0, 20, 22);
    levelEntry <= 1'b1;
    @(posedge core_clk);
    levelEntry <= 1'b0;
    span(1, 10, 12);
    levelDqsRise <= 1'b1;
    @(posedge core_clk);
    levelDqsRise <= 1'b0;
    span(2, 12, 14);
    ckeLow <= 1'b1;
    span(4, 1, 1999);
    ckeLow <= 1'b0;
    span(3, 5, 7);
    step(CMD_ACT, 0, 0, 0);
    step(CMD_ACT, 1, 0, 5);
    step(CMD_RD, 1, 0, 6);
    step(CMD_RD, 1, 0, 5);
    step(CMD_PRE, 1, 0, 3);
    step(CMD_PRE, 0, 0, 7);
    step(CMD_ACT, 0, 0, 14);
    step(CMD_PRE, 0, 0, 9);
    step(CMD_REF, 0, 0, 7);
    step(CMD_REF, 0, 0, 30);
    step(CMD_ACT, 2, 0, 30);
    step(CMD_WR, 2, 0, 6);
    step(CMD_WR, 2, 0, 5);
    step(CMD_RD, 2, 0, 8);
    step(CMD_WR, 2, 0, 4);
    step(CMD_PRE, 2, 0, 0);
    step(CMD_MRS, 0, 0, 7);
    step(CMD_MRS, 0, 0, 7);
    step(CMD_ACT, 3, 0, 17);
    for (int i = 4; i < 7; i++)
      step(CMD_ACT, i, 0, 5);
    step(CMD_ACT, 7, 0, 25);
    step(CMD_PDX, 0, 0, 0);
    step(CMD_RD, 7, 0, 9);
    step(CMD_PDX, 0, 1, 0);
    step(CMD_RD, 7, 0, 40);
    cmdReq <= '0;
    repeat (2) @(posedge core_clk);
    check(protoErr, 32'h0);
    check(issueCnt, 32'd27);
    final_report();
  end
endmodule
bind dtp_ddr3_timing dtp_ddr3_timing_asserts u_chk (.core_clk(core_clk), .arst_n(arst_n),
  .cmdReq(cmdReq), .cmdIssue(cmdIssue), .cmdReady(cmdReady), .ckeOut(ckeOut),
  .dllRelock(dllRelock), .dllLocked(dllLocked), .levelEntry(levelEntry),
  .levelStrobeOk(levelStrobeOk), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready));

// >>> dtp_params.svh
// Register map, reset values and fixed timing base counts of the timing parameter block
`ifndef DTP_PARAMS_SVH
`define DTP_PARAMS_SVH
`define DTP_OFF_SYSCFG 4'h0
`define DTP_OFF_TPA 4'h4
`define DTP_OFF_TPB 4'h8
`define DTP_OFF_TPC 4'hC
`define DTP_RST_SYSCFG 32'h0000040B
`define DTP_RST_TPA 32'hC9E4EE88
`define DTP_RST_TPB 32'h228BB4D2
`define DTP_RST_TPC 32'h10036A00
`define DTP_MOD_BASE 6'h0C
`define DTP_MRD_BASE 6'h04
`define DTP_CCD_BASE 6'h04
`define DTP_RTW_BASE 6'h02
`define DTP_RTODT_BASE 6'h01
`define DTP_FAW_ACTS 3'h4
`define DTP_BANKS 8
`define DTP_RESP_OKAY 2'h0
`define DTP_RESP_SLVERR 2'h2
`endif

// >>> dtp_pkg.sv
// Types of the timing parameter block
package dtp_pkg;
  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_PRE, CMD_RD, CMD_WR, CMD_REF, CMD_MRS, CMD_PDX
  } dtp_cmd_e_t;
  typedef struct packed {
    logic valid;
    dtp_cmd_e_t cmd;
    logic [2:0] bank;
    logic srefExit;
  } dtp_req_t;
  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } dtp_chan_t;
endpackage

// >>> dtp_sdram_model.sv
// Behavioural DDR3 device watching the issued command stream
`timescale 1ns/100ps
module dtp_sdram_model
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire dtp_pkg::dtp_req_t cmdIssue,
  input wire logic ckeOut,
  output logic [7:0] protoErr,
  output logic [7:0] issueCnt
);
  import dtp_pkg::*;
  logic [7:0] openBank_q;
  logic bad;
  // ==========
  // Bank state; refresh or mode write needs every bank closed
  assign bad = (cmdIssue.cmd == CMD_ACT && openBank_q[cmdIssue.bank])
    || ((cmdIssue.cmd == CMD_RD || cmdIssue.cmd == CMD_WR) && !openBank_q[cmdIssue.bank])
    || ((cmdIssue.cmd == CMD_REF || cmdIssue.cmd == CMD_MRS) && (|openBank_q))
    || (cmdIssue.cmd != CMD_PDX && !ckeOut);
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      openBank_q <= 8'h00;
      protoErr <= 8'h00;
      issueCnt <= 8'h00;
    end
    else if (cmdIssue.valid)
    begin
      issueCnt <= issueCnt + 8'h01;
      protoErr <= protoErr + {7'h00, bad};
      if (cmdIssue.cmd == CMD_ACT)
        openBank_q[cmdIssue.bank] <= 1'b1;
      if (cmdIssue.cmd == CMD_PRE)
        openBank_q[cmdIssue.bank] <= 1'b0;
    end
  end
endmodule
